// ==== hdl/tios_pkg.sv ====
// Constants, register map and carrier types for the channel 4/5 pin A I/O selection block
// Functional notes
// - Output compare with bit 2 clear and bits 1..0 nonzero starts the pin at low.
// - Output compare with bit 2 set and bits 1..0 nonzero starts the pin at high.
// - Output compare with bits 1..0 at 01 drives the pin to 0 on a counter match.
// - Output compare with bits 1..0 at 10 drives the pin to 1 on a counter match.
// - Output compare with bits 1..0 at 11 inverts the pin on every counter match.
// - Channel 4 selection 1000 captures on rising edges of its pin A.
// - Channel 4 selection 1001 captures on falling edges of its pin A.
// - Channel 4 selection 101X captures on both edges of its pin A.
// - Channel 4 selection 11XX captures on each channel 3 register A match or capture.
// - Channel 5 with bit 3 set captures from its pin A, bit 2 ignored, edge by bits 1..0.
// - Channel 3 capture on channel 4 count is ignored while the channel 4 prescaler is 000.
// - With channel 3 buffer mode set, register C selection produces no event at all.
package tios_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CH4_SEL = 8'h00;
   localparam logic [7:0] OFS_CH5_SEL = 8'h04;
   localparam logic [7:0] OFS_CH4_GRA = 8'h08;
   localparam logic [7:0] OFS_CH5_GRA = 8'h0c;
   localparam logic [7:0] OFS_CH4_CNT = 8'h10;
   localparam logic [7:0] OFS_CH5_CNT = 8'h14;
   localparam logic [7:0] OFS_CH3_CTL = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;

   // Selection field positions
   localparam int FUNC_BIT3 = 3;
   localparam int FUNC_BIT2 = 2;
   localparam int FUNC_BIT1 = 1;
   localparam int FUNC_BIT0 = 0;

   // Channel 3 control word layout
   localparam int CTL_A_SEL_LSB = 0;
   localparam int CTL_C_SEL_LSB = 4;
   localparam int CTL_BUF_MODE = 8;
   localparam int CTL_PSC_LSB = 9;

   // Reset values
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [3:0] CH3_SEL_RST = 4'h0;
   localparam logic [2:0] PSC_RST = 3'h0;
   localparam logic [2:0] PSC_FULL_RATE = 3'h0;
   localparam logic [31:0] GRA_RST = 32'hffffffff;

   // Compare-match pin actions in bits 1..0
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   // Pin carrier: level and output enable
   typedef struct packed {
      logic lvl;
      logic oe;
   } tios_pin_t;

endpackage

// ==== hdl/tios_top.sv ====
// Pin A I/O selection, compare and capture logic for timer channels 4 and 5
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module tios_top #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Channel 3 register A event, same clock
   input wire logic ch3_gra_event_i,
   // Pins
   input wire logic ch4_pin_a_i,
   input wire logic ch5_pin_a_i,
   output tios_pkg::tios_pin_t ch4_pin_a_o,
   output tios_pkg::tios_pin_t ch5_pin_a_o,
   // Event outputs
   output logic ch4_capture_o,
   output logic ch5_capture_o,
   output logic ch3_a_count_cap_o,
   output logic ch3_c_count_cap_o,
   output logic ch3_c_active_o
);

   // Width limits of the counters and registers
   if (CNT_W < 8 || CNT_W > 32) begin : g_chk
      $error("tios_top: CNT_W must lie in 8..32");
   end

   // Capture decision; only channel 4 has the channel 3 source
   function automatic logic cap_hit(input logic [3:0] sel, input logic rise,
                                    input logic fall, input logic ch3ev,
                                    input logic is_ch4);
      logic hit;
      hit = 1'b0;
      if (sel[tios_pkg::FUNC_BIT3]) begin
         if (is_ch4 && sel[tios_pkg::FUNC_BIT2]) begin
            hit = ch3ev;
         end else if (sel[tios_pkg::FUNC_BIT1]) begin
            hit = rise | fall;
         end else if (sel[tios_pkg::FUNC_BIT0]) begin
            hit = fall;
         end else begin
            hit = rise;
         end
      end
      return hit;
   endfunction

   // Output compare mode with a live pin
   function automatic logic oc_drive(input logic [3:0] sel);
      return !sel[tios_pkg::FUNC_BIT3] && (sel[1:0] != tios_pkg::ACT_OFF);
   endfunction

   // Prescaler mask: 2**psc - 1
   function automatic logic [6:0] psc_mask(input logic [2:0] psc);
      return 7'((8'h01 << psc) - 8'h01);
   endfunction

   logic [7:0] sel_q [2];
   logic [CNT_W-1:0] gra_q [2];
   logic [CNT_W-1:0] cnt_q [2];
   tios_pkg::tios_pin_t pin_q [2];
   logic [3:0] ch3_a_sel_q;
   logic [3:0] ch3_c_sel_q;
   logic buf_mode_q;
   logic [2:0] psc_q;
   logic [6:0] div_q;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;
   logic [1:0] cap_q;
   logic ch3_a_cap_q;
   logic ch3_c_cap_q;
   logic ch3_c_active_q;
   logic [31:0] rdata_q;
   logic ch4_tick;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] cap_now;
   logic [1:0] match;
   logic [1:0] sel_wr;
   logic [1:0] gra_wr;
   logic ctl_wr;

   // Write decodes
   assign sel_wr[0] = wr_i && (addr_i == tios_pkg::OFS_CH4_SEL);
   assign sel_wr[1] = wr_i && (addr_i == tios_pkg::OFS_CH5_SEL);
   assign gra_wr[0] = wr_i && (addr_i == tios_pkg::OFS_CH4_GRA);
   assign gra_wr[1] = wr_i && (addr_i == tios_pkg::OFS_CH5_GRA);
   assign ctl_wr = wr_i && (addr_i == tios_pkg::OFS_CH3_CTL);

   // Selection registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_q[0] <= tios_pkg::SEL_RST;
         sel_q[1] <= tios_pkg::SEL_RST;
      end else begin
         if (sel_wr[0]) begin
            sel_q[0] <= wdata_i[7:0];
         end
         if (sel_wr[1]) begin
            sel_q[1] <= wdata_i[7:0];
         end
      end
   end

   // Channel 3 side controls and channel 4 prescaler
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ch3_a_sel_q <= tios_pkg::CH3_SEL_RST;
         ch3_c_sel_q <= tios_pkg::CH3_SEL_RST;
         buf_mode_q <= 1'b0;
         psc_q <= tios_pkg::PSC_RST;
      end else if (ctl_wr) begin
         ch3_a_sel_q <= wdata_i[tios_pkg::CTL_A_SEL_LSB +: 4];
         ch3_c_sel_q <= wdata_i[tios_pkg::CTL_C_SEL_LSB +: 4];
         buf_mode_q <= wdata_i[tios_pkg::CTL_BUF_MODE];
         psc_q <= wdata_i[tios_pkg::CTL_PSC_LSB +: 3];
      end
   end

   // Prescale divider; psc 000 ticks every cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q <= 7'h00;
      end else begin
         div_q <= div_q + 7'h01;
      end
   end
   assign ch4_tick = (div_q & psc_mask(psc_q)) == 7'h00;

   // Counters: channel 4 on prescaled tick, channel 5 every cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q[0] <= '0;
         cnt_q[1] <= '0;
      end else begin
         if (ch4_tick) begin
            cnt_q[0] <= cnt_q[0] + CNT_W'(1);
         end
         cnt_q[1] <= cnt_q[1] + CNT_W'(1);
      end
   end

   // Pin synchronisers; third stage only for edge detection
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
      end else begin
         pin_s1_q <= {ch5_pin_a_i, ch4_pin_a_i};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign rise = pin_s2_q & ~pin_s3_q;
   assign fall = ~pin_s2_q & pin_s3_q;

   // Capture and compare conditions per channel
   assign cap_now[0] = cap_hit(sel_q[0][3:0], rise[0], fall[0], ch3_gra_event_i, 1'b1);
   assign cap_now[1] = cap_hit(sel_q[1][3:0], rise[1], fall[1], 1'b0, 1'b0);
   assign match[0] = !sel_q[0][tios_pkg::FUNC_BIT3] && (cnt_q[0] == gra_q[0]);
   assign match[1] = !sel_q[1][tios_pkg::FUNC_BIT3] && (cnt_q[1] == gra_q[1]);

   // General register A; a capture beats a software write in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gra_q[0] <= tios_pkg::GRA_RST[CNT_W-1:0];
         gra_q[1] <= tios_pkg::GRA_RST[CNT_W-1:0];
         cap_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_now[i]) begin
               gra_q[i] <= cnt_q[i];
            end else if (gra_wr[i]) begin
               gra_q[i] <= wdata_i[CNT_W-1:0];
            end
         end
         cap_q <= cap_now;
      end
   end

   // Pin level and enable; a selection write sets the initial level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_q[0] <= '0;
         pin_q[1] <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sel_wr[i]) begin
               pin_q[i].oe <= oc_drive(wdata_i[3:0]);
               if (oc_drive(wdata_i[3:0])) begin
                  pin_q[i].lvl <= wdata_i[tios_pkg::FUNC_BIT2];
               end
            end else if (match[i]) begin
               case (sel_q[i][1:0])
                  tios_pkg::ACT_LOW: pin_q[i].lvl <= 1'b0;
                  tios_pkg::ACT_HIGH: pin_q[i].lvl <= 1'b1;
                  tios_pkg::ACT_TOGGLE: pin_q[i].lvl <= ~pin_q[i].lvl;
                  default: pin_q[i].lvl <= pin_q[i].lvl;
               endcase
            end
         end
      end
   end

   // Channel 3 count-clock captures; void at full rate, register C also under buffer mode
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ch3_a_cap_q <= 1'b0;
         ch3_c_cap_q <= 1'b0;
         ch3_c_active_q <= 1'b1;
      end else begin
         ch3_a_cap_q <= (ch3_a_sel_q[3:2] == 2'h3) && ch4_tick
            && (psc_q != tios_pkg::PSC_FULL_RATE);
         ch3_c_cap_q <= (ch3_c_sel_q[3:2] == 2'h3) && ch4_tick && !buf_mode_q
            && (psc_q != tios_pkg::PSC_FULL_RATE);
         ch3_c_active_q <= !buf_mode_q;
      end
   end

   // Read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            tios_pkg::OFS_CH4_SEL: rdata_q <= {24'h000000, sel_q[0]};
            tios_pkg::OFS_CH5_SEL: rdata_q <= {24'h000000, sel_q[1]};
            tios_pkg::OFS_CH4_GRA: rdata_q <= 32'(gra_q[0]);
            tios_pkg::OFS_CH5_GRA: rdata_q <= 32'(gra_q[1]);
            tios_pkg::OFS_CH4_CNT: rdata_q <= 32'(cnt_q[0]);
            tios_pkg::OFS_CH5_CNT: rdata_q <= 32'(cnt_q[1]);
            tios_pkg::OFS_CH3_CTL: rdata_q <= {20'h00000, psc_q, buf_mode_q,
                                               ch3_c_sel_q, ch3_a_sel_q};
            tios_pkg::OFS_STATUS: rdata_q <= {27'h0000000, ch3_c_active_q,
                                              pin_q[1].oe, pin_q[1].lvl,
                                              pin_q[0].oe, pin_q[0].lvl};
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   // Outputs straight from flops
   assign rdata_o = rdata_q;
   assign ch4_pin_a_o = pin_q[0];
   assign ch5_pin_a_o = pin_q[1];
   assign ch4_capture_o = cap_q[0];
   assign ch5_capture_o = cap_q[1];
   assign ch3_a_count_cap_o = ch3_a_cap_q;
   assign ch3_c_count_cap_o = ch3_c_cap_q;
   assign ch3_c_active_o = ch3_c_active_q;

   // Checks on the selection behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_init_low: assert property (
      sel_wr[0] && !wdata_i[3] && !wdata_i[2] && (wdata_i[1:0] != 2'h0)
      |=> !ch4_pin_a_o.lvl && ch4_pin_a_o.oe)
      else $error("initial low level not driven");

   a_init_high: assert property (
      sel_wr[1] && !wdata_i[3] && wdata_i[2] && (wdata_i[1:0] != 2'h0)
      |=> ch5_pin_a_o.lvl && ch5_pin_a_o.oe)
      else $error("initial high level not driven");

   a_match_low: assert property (
      !sel_wr[0] && match[0] && (sel_q[0][3:0] ==? 4'b0?01) |=> !ch4_pin_a_o.lvl)
      else $error("match did not drive low");

   a_match_high: assert property (
      !sel_wr[0] && match[0] && (sel_q[0][3:0] ==? 4'b0?10) |=> ch4_pin_a_o.lvl)
      else $error("match did not drive high");

   a_match_toggle: assert property (
      !sel_wr[1] && match[1] && (sel_q[1][3:0] ==? 4'b0?11)
      |=> ch5_pin_a_o.lvl != $past(ch5_pin_a_o.lvl))
      else $error("match did not toggle");

   a_output_off: assert property (
      sel_wr[0] && (wdata_i[3:0] ==? 4'b0?00) |=> !ch4_pin_a_o.oe ##1 !ch4_pin_a_o.oe
      or sel_wr[0])
      else $error("disabled output still enabled");

   a_rise_copy: assert property (
      (sel_q[0][3:0] == 4'h8) && rise[0] |=> ch4_capture_o && gra_q[0] == $past(cnt_q[0]))
      else $error("rising capture missed");

   a_fall_only: assert property (
      (sel_q[0][3:0] == 4'h9) && rise[0] && !fall[0] |=> !ch4_capture_o)
      else $error("falling selection captured a rise");

   a_both_edges: assert property (
      (sel_q[0][3:1] == 3'h5) && (rise[0] || fall[0]) |=> ch4_capture_o)
      else $error("both-edge capture missed");

   a_ch3_source: assert property (
      (sel_q[0][3:2] == 2'h3) |=> (ch4_capture_o == $past(ch3_gra_event_i)))
      else $error("channel 3 source not followed");

   a_ch5_edges: assert property (
      sel_q[1][3] && (sel_q[1][1:0] == 2'h0) && rise[1] |=> ch5_capture_o
      && gra_q[1] == $past(cnt_q[1]))
      else $error("channel 5 capture wrong");

   a_full_rate: assert property (
      (psc_q == tios_pkg::PSC_FULL_RATE) && !ctl_wr |=> !ch3_a_count_cap_o)
      else $error("capture at full rate not ignored");

   a_buffer_void: assert property (
      buf_mode_q && !ctl_wr |=> !ch3_c_count_cap_o && !ch3_c_active_o)
      else $error("register C active under buffer mode");

   a_capture_copy: assert property (
      cap_now[1] |=> gra_q[1] == $past(cnt_q[1]))
      else $error("capture did not copy counter");

   a_ch4_init_high: assert property (
      sel_wr[0] && !wdata_i[3] && wdata_i[2] && (wdata_i[1:0] != 2'h0)
      |=> ch4_pin_a_o.lvl && ch4_pin_a_o.oe)
      else $error("channel 4 initial high level not driven");

   a_ch5_falling: assert property (
      sel_q[1][3] && (sel_q[1][1:0] == 2'h1) && fall[1] |=> ch5_capture_o)
      else $error("channel 5 falling capture missed");

   a_capture_no_drive: assert property (
      sel_wr[1] && wdata_i[3] |=> !ch5_pin_a_o.oe)
      else $error("capture setting still drives the pin");

   c_ch4_capture: cover property (cap_now[0] ##1 ch4_capture_o);
   c_ch5_toggle: cover property (match[1] && sel_q[1][1:0] == 2'h3);
   c_ch3_count: cover property (ch3_a_count_cap_o);
   c_buffer_mode: cover property (buf_mode_q ##1 !ch3_c_active_o);
   c_both_fall: cover property ((sel_q[0][3:1] == 3'h5) && fall[0] ##1 ch4_capture_o);

endmodule

// ==== verif/tios_pin_model.sv ====
// Wire model of the channel 4/5 pin A lines seen from outside the timer
`timescale 1ns/1ps
module tios_pin_model (
   // Levels forced by the outside source when the timer lets go
   input wire logic [1:0] ext_i,
   // Timer pin drivers
   input wire tios_pkg::tios_pin_t pin4_i,
   input wire tios_pkg::tios_pin_t pin5_i,
   // Resolved wire levels fed back to the timer
   output logic wire4_o,
   output logic wire5_o
);
   // A driving timer wins, so output compare levels read back on the pin
   assign wire4_o = pin4_i.oe ? pin4_i.lvl : ext_i[0];
   assign wire5_o = pin5_i.oe ? pin5_i.lvl : ext_i[1];
endmodule

// ==== verif/tios_top_test.sv ====
// Self-checking bench for the channel 4/5 pin A selection block
`timescale 1ns/1ps
module tios_top_test;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic ch3_gra_event_i = 1'b0;
   logic [31:0] rdata_o;
   logic ch4_pin_a_i, ch5_pin_a_i, ch4_capture_o, ch5_capture_o;
   logic ch3_a_count_cap_o, ch3_c_count_cap_o, ch3_c_active_o;
   tios_pkg::tios_pin_t ch4_pin_a_o, ch5_pin_a_o, p;
   logic [1:0] ext = 2'h0;
   logic [31:0] v, c;
   int n[4] = '{0, 0, 0, 0};
   int mismatches = 0;
   int checked = 0;

   tios_top #(.CNT_W(16)) i_tios_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .ch3_gra_event_i(ch3_gra_event_i), .ch4_pin_a_i(ch4_pin_a_i),
      .ch5_pin_a_i(ch5_pin_a_i), .ch4_pin_a_o(ch4_pin_a_o), .ch5_pin_a_o(ch5_pin_a_o),
      .ch4_capture_o(ch4_capture_o), .ch5_capture_o(ch5_capture_o),
      .ch3_a_count_cap_o(ch3_a_count_cap_o), .ch3_c_count_cap_o(ch3_c_count_cap_o),
      .ch3_c_active_o(ch3_c_active_o));
   tios_pin_model i_tios_pin_model (.ext_i(ext), .pin4_i(ch4_pin_a_o), .pin5_i(ch5_pin_a_o),
      .wire4_o(ch4_pin_a_i), .wire5_o(ch5_pin_a_i));

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   // Event tallies; the sequence clears them between steps
   always @(posedge clk_i) begin
      if (ch4_capture_o === 1'b1) n[0]++;
      if (ch5_capture_o === 1'b1) n[1]++;
      if (ch3_a_count_cap_o === 1'b1) n[2]++;
      if (ch3_c_count_cap_o === 1'b1) n[3]++;
   end

   task automatic end_of_test();
      $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask

   task automatic setpin(input int ch, input logic l);
      @(posedge clk_i);
      ext[ch] <= l;
      cyc(6);
   endtask

   // Pin pulse under a capture setting; the gap covers the two-flop synchroniser
   task automatic cap(input int ch, input logic [3:0] s, input int exp);
      wr(8'(4 * ch), 32'(s));
      cyc(6);
      n[ch] = 0;
      setpin(ch, 1'b1);
      setpin(ch, 1'b0);
      chk(32'(n[ch]), 32'(exp), "capture count");
      rd(8'(8 + 4 * ch), v);
      rd(8'(16 + 4 * ch), c);
      chk(32'(((c - v) & 32'hffff) < 32'd24), 32'h1, "captured counter");
   endtask

   initial begin
      #100us;
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // Reset values and plain register access, unmapped place included
      rd(8'h00, v);
      chk(v, 32'h0, "ch4 select reset");
      rd(8'h08, v);
      chk(v, 32'hffff, "ch4 reg A reset");
      rd(8'h1c, v);
      chk(v, 32'h10, "status reset");
      rd(8'h20, v);
      chk(v, 32'h0, "unmapped read");
      wr(8'h04, 32'ha5);
      rd(8'h04, v);
      chk(v, 32'ha5, "ch5 select readback");
      $display("test registers done");
      // Every output compare setting on both channels
      for (int ch = 0; ch < 2; ch++) begin
         for (int s = 0; s < 8; s++) begin
            wr(8'(4 * ch), 32'(s));
            p = ch ? ch5_pin_a_o : ch4_pin_a_o;
            chk(32'(p.oe), 32'(s[1:0] != 2'h0), "pin enable");
            if (s[1:0] != 2'h0) chk(32'(p.lvl), 32'(s[2]), "initial level");
         end
      end
      $display("test initial levels done");
      // Two matches in a row tell force from toggle
      for (int ch = 0; ch < 2; ch++) begin
         foreach (n[k]) begin
            v = 32'({4'h5, 4'h2, 4'h7, 4'h3} >> (12 - 4 * k)) & 32'hf;
            wr(8'(4 * ch), v);
            rd(8'(4 * ch), c);
            chk(c, v, "select readback");
            for (int m = 1; m < 3; m++) begin
               rd(8'(16 + 4 * ch), c);
               wr(8'(8 + 4 * ch), c + 32'd40);
               cyc(50);
               p = ch ? ch5_pin_a_o : ch4_pin_a_o;
               c = (v[1:0] == 2'h3) ? 32'(v[2] ^ m[0]) : 32'(v[1]);
               chk(32'(p.lvl), c, "level after match");
            end
         end
      end
      $display("test compare done");
      cap(0, 4'h8, 1);
      cap(0, 4'h9, 1);
      cap(0, 4'ha, 2);
      cap(0, 4'hb, 2);
      cap(1, 4'h8, 1);
      cap(1, 4'hc, 1);
      cap(1, 4'hd, 1);
      cap(1, 4'hf, 2);
      $display("test pin capture done");
      // Channel 3 register A event as capture source
      for (int s = 12; s < 16; s += 3) begin
         wr(8'h00, 32'(s));
         cyc(6);
         n[0] = 0;
         @(posedge clk_i);
         ch3_gra_event_i <= 1'b1;
         @(posedge clk_i);
         ch3_gra_event_i <= 1'b0;
         #1;
         chk(32'(ch4_capture_o), 32'h1, "chained capture pulse");
         cyc(6);
         chk(32'(n[0]), 32'h1, "chained capture count");
      end
      $display("test chained capture done");
      // Count-clock capture blocked at full rate, live when divided
      for (int d = 0; d < 2; d++) begin
         wr(8'h18, 32'h0cc | (32'(d) << 9));
         cyc(4);
         n[2] = 0;
         n[3] = 0;
         cyc(20);
         chk(32'(n[2] > 0), 32'(d), "ch3 A count capture");
         chk(32'(n[3] > 0), 32'(d), "ch3 C count capture");
      end
      // Buffer mode voids the register C setting
      wr(8'h18, 32'h3cc);
      cyc(4);
      n[3] = 0;
      cyc(20);
      chk(32'(n[3]), 32'h0, "C capture in buffer mode");
      chk(32'(ch3_c_active_o), 32'h0, "C active in buffer mode");
      rd(8'h1c, v);
      chk(v & 32'h10, 32'h0, "status C active bit");
      $display("test channel 3 conditions done");
      end_of_test();
   end
endmodule
